// ==== hdl/pvb_defines.svh ====
// Register map, reset values and timing counts of the PLL band select control
// Functional notes
// (R1) VCO range split into 64 overlapping bands, chosen by a 6-bit value.
// (R2) Writing control 0xc0 then 0x80 at offset 0x12 starts auto calibration.
// (R3) After the trigger the device searches the best band on its own.
// (R4) Control bit 6: 1 manual band, 0 automatic band.
// (R5) Manual mode drives the VCO band from control bits 5 to 0.
// (R6) Control bit 7 set to 1 enables the PLL.
// (R7) Host auto start: dividers, loop, mode manual, enable, then mode automatic.
// (R8) Host manual start: dividers, loop, band field, mode manual, then enable.
// (R9) Loop settings reset to 0xe7: pump current 00111b, bandwidth 111b.
// (R10) Host waits 10 ms, reads lock bit 7 of status; device sets it when locked. Here it reads 0 while disabled or calibrating.
// (R11) Loop settings bits 7:5 bandwidth, bits 4:0 charge pump current.
// (R12) Enable 0 powers the multiplier down and selects the direct clock input.
// (R13) VCO and loop divider ratios are programmed at offset 0x15.
// (R14) Calibration starts only on manual-to-auto change while enable is set.
`ifndef PVB_DEFINES_SVH
`define PVB_DEFINES_SVH

`define PVB_ADDR_CONTROL    8'h12
`define PVB_ADDR_LOOP       8'h14
`define PVB_ADDR_DIVIDER    8'h15
`define PVB_ADDR_STATUS     8'h16

`define PVB_CTRL_ENABLE_BIT 7
`define PVB_CTRL_MANUAL_BIT 6
`define PVB_CTRL_BAND_MSB   5
`define PVB_CTRL_BAND_LSB   0
`define PVB_LOOP_BW_MSB     7
`define PVB_LOOP_BW_LSB     5
`define PVB_LOOP_CP_MSB     4
`define PVB_LOOP_CP_LSB     0
`define PVB_STAT_LOCK_BIT   7
`define PVB_STAT_BUSY_BIT   6

`define PVB_RST_CONTROL     8'h00
`define PVB_RST_LOOP        8'he7
`define PVB_RST_DIVIDER     8'h00

`define PVB_BAND_W          6
`define PVB_CLK_PERIOD_NS   8
`define PVB_SETTLE_TIME_NS  100000
`define PVB_SETTLE_CYCLES   ((`PVB_SETTLE_TIME_NS + `PVB_CLK_PERIOD_NS - 1) / `PVB_CLK_PERIOD_NS)

`endif

// ==== hdl/pvb_pkg.sv ====
// Types of the PLL band select control
package pvb_pkg;
  typedef enum logic [2:0] {
    CAL_IDLE   = 3'b001,
    CAL_SETTLE = 3'b010,
    CAL_DECIDE = 3'b100
  } pvb_cal_state_t;
endpackage : pvb_pkg

// ==== hdl/pvb_band_cal.sv ====
// Successive approximation search for the VCO tuning band
`timescale 1ns/1ps
`default_nettype none
module pvb_band_cal #(
  parameter int BAND_W        = 6,
  parameter int SETTLE_CYCLES = 12500
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Control
  input  wire logic              start,
  input  wire logic              abort,
  input  wire logic              vco_fast,
  // Result
  output logic                   busy,
  output logic [BAND_W-1:0]      band
);
  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam int IDX_W = (BAND_W > 1) ? $clog2(BAND_W) : 1;
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [IDX_W-1:0] IDX_TOP  = IDX_W'(BAND_W - 1);

  initial begin
    if (BAND_W < 1 || SETTLE_CYCLES < 1) begin
      $error("pvb_band_cal: BAND_W and SETTLE_CYCLES must be at least 1");
    end
  end

  pvb_pkg::pvb_cal_state_t state;
  logic [CNT_W-1:0]        cnt;
  logic [IDX_W-1:0]        idx;

  assign busy = (state != pvb_pkg::CAL_IDLE);

  // One band bit decided per settle period, most significant first
  always_ff @(posedge clk) begin
    if (rst || abort) begin
      state <= pvb_pkg::CAL_IDLE;
      cnt   <= '0;
      idx   <= '0;
    end else begin
      unique case (state)
        pvb_pkg::CAL_IDLE: begin
          if (start) begin // R3
            state <= pvb_pkg::CAL_SETTLE;
            cnt   <= CNT_LOAD;
            idx   <= IDX_TOP;
          end
        end
        pvb_pkg::CAL_SETTLE: begin
          if (cnt == '0) begin
            state <= pvb_pkg::CAL_DECIDE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        pvb_pkg::CAL_DECIDE: begin
          if (idx == '0) begin
            state <= pvb_pkg::CAL_IDLE;
          end else begin
            state <= pvb_pkg::CAL_SETTLE;
            cnt   <= CNT_LOAD;
            idx   <= idx - 1'b1;
          end
        end
      endcase
    end
  end

  // Trial band: keep a bit only while the VCO is not above target
  always_ff @(posedge clk) begin
    if (rst) begin
      band <= '0;
    end else if (state == pvb_pkg::CAL_IDLE && start && !abort) begin
      band <= BAND_W'(1) << (BAND_W - 1); // R1
    end else if (state == pvb_pkg::CAL_DECIDE && !abort) begin
      if (vco_fast) begin
        band[idx] <= 1'b0;
      end
      if (idx != '0) begin
        band[idx - 1'b1] <= 1'b1;
      end
    end
  end
endmodule : pvb_band_cal
`default_nettype wire

// ==== hdl/pvb_top.sv ====
// PLL enable, loop settings and VCO band selection control
`timescale 1ns/1ps
`default_nettype none
`include "pvb_defines.svh"
module pvb_top #(
  parameter int SETTLE_CYCLES = `PVB_SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Register access
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WE,
  input  wire logic       REG_RE,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  // Analog PLL status
  input  wire logic       PLL_LOCK_IN,
  input  wire logic       VCO_FAST_IN,
  // PLL controls
  output logic            PLL_POWER_UP,
  output logic            CLK_SEL_PLL,
  output logic      [5:0] VCO_BAND,
  output logic      [2:0] LOOP_BW,
  output logic      [4:0] CP_CURRENT,
  output logic      [7:0] DIV_SETTING,
  output logic            CAL_BUSY
);
  initial begin
    if (SETTLE_CYCLES < 1) begin
      $error("pvb_top: SETTLE_CYCLES must be at least 1");
    end
  end

  logic [7:0] control;
  logic [7:0] loop_settings;
  logic [7:0] divider;
  logic [1:0] lock_sync;
  logic [1:0] fast_sync;
  logic       cal_start;
  logic       cal_abort;
  logic       cal_busy;
  logic [5:0] cal_band;
  logic       wr_control;
  logic       lock_status;
  logic [7:0] status_word;

  assign wr_control = REG_WE && (REG_ADDR == `PVB_ADDR_CONTROL);

  // Mode bit falling while the new value keeps the enable: 0xc0 then 0x80
  assign cal_start = wr_control                                   // R2
                   && control[`PVB_CTRL_MANUAL_BIT]               // R14
                   && !REG_WDATA[`PVB_CTRL_MANUAL_BIT]
                   && REG_WDATA[`PVB_CTRL_ENABLE_BIT];

  // A search is meaningless once the loop is off or handed to manual
  // Start wins: the old control still shows manual in the trigger cycle
  assign cal_abort = !cal_start
                   && (!control[`PVB_CTRL_ENABLE_BIT] || control[`PVB_CTRL_MANUAL_BIT]);

  assign lock_status = lock_sync[1] && control[`PVB_CTRL_ENABLE_BIT] && !cal_busy;

  assign status_word = {lock_status, cal_busy, VCO_BAND};

  // Analog levels arrive unrelated to CLK
  always_ff @(posedge CLK) begin
    if (RST) begin
      lock_sync <= 2'h0;
      fast_sync <= 2'h0;
    end else begin
      lock_sync <= {lock_sync[0], PLL_LOCK_IN};
      fast_sync <= {fast_sync[0], VCO_FAST_IN};
    end
  end

  // Control register
  always_ff @(posedge CLK) begin
    if (RST) begin
      control <= `PVB_RST_CONTROL;
    end else if (wr_control) begin
      control <= REG_WDATA; // R4
    end
  end

  // Loop settings register
  always_ff @(posedge CLK) begin
    if (RST) begin
      loop_settings <= `PVB_RST_LOOP; // R9
    end else if (REG_WE && REG_ADDR == `PVB_ADDR_LOOP) begin
      loop_settings <= REG_WDATA;
    end
  end

  // Divider register
  always_ff @(posedge CLK) begin
    if (RST) begin
      divider <= `PVB_RST_DIVIDER;
    end else if (REG_WE && REG_ADDR == `PVB_ADDR_DIVIDER) begin
      divider <= REG_WDATA; // R13
    end
  end

  // Read port: one cycle latency, unmapped offsets read zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RE;
      if (REG_RE) begin
        unique case (REG_ADDR)
          `PVB_ADDR_CONTROL: REG_RDATA <= control;
          `PVB_ADDR_LOOP:    REG_RDATA <= loop_settings;
          `PVB_ADDR_DIVIDER: REG_RDATA <= divider;
          `PVB_ADDR_STATUS:  REG_RDATA <= status_word; // R10
          default:           REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  pvb_band_cal #(
    .BAND_W        (`PVB_BAND_W),
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_band_cal (
    .clk      (CLK),
    .rst      (RST),
    .start    (cal_start),
    .abort    (cal_abort),
    .vco_fast (fast_sync[1]),
    .busy     (cal_busy),
    .band     (cal_band)
  );

  // Enable and clock source
  always_ff @(posedge CLK) begin
    if (RST) begin
      PLL_POWER_UP <= 1'b0;
      CLK_SEL_PLL  <= 1'b0;
    end else begin
      PLL_POWER_UP <= control[`PVB_CTRL_ENABLE_BIT]; // R6
      CLK_SEL_PLL  <= control[`PVB_CTRL_ENABLE_BIT]; // R12
    end
  end

  // Band steering; auto band holds its last search result
  always_ff @(posedge CLK) begin
    if (RST) begin
      VCO_BAND <= 6'h00;
    end else if (control[`PVB_CTRL_MANUAL_BIT]) begin
      VCO_BAND <= control[`PVB_CTRL_BAND_MSB:`PVB_CTRL_BAND_LSB]; // R5
    end else begin
      VCO_BAND <= cal_band; // R3
    end
  end

  // Loop fields, dividers and busy flag
  always_ff @(posedge CLK) begin
    if (RST) begin
      LOOP_BW     <= 3'h0;
      CP_CURRENT  <= 5'h00;
      DIV_SETTING <= 8'h00;
      CAL_BUSY    <= 1'b0;
    end else begin
      LOOP_BW     <= loop_settings[`PVB_LOOP_BW_MSB:`PVB_LOOP_BW_LSB]; // R11
      CP_CURRENT  <= loop_settings[`PVB_LOOP_CP_MSB:`PVB_LOOP_CP_LSB]; // R11
      DIV_SETTING <= divider;
      CAL_BUSY    <= cal_busy;
    end
  end
endmodule : pvb_top
`default_nettype wire

// ==== test/pvb_properties.sv ====
// Port assertions of the PLL band select control
`timescale 1ns/1ps
`default_nettype none
module pvb_properties #(
  parameter int SETTLE_CYCLES = 4
) (
  // Clock, reset and registers
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WE,
  input wire logic       REG_RE,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_RVALID,
  // PLL controls
  input wire logic       PLL_POWER_UP,
  input wire logic       CLK_SEL_PLL,
  input wire logic [5:0] VCO_BAND,
  input wire logic [2:0] LOOP_BW,
  input wire logic [4:0] CP_CURRENT,
  input wire logic       CAL_BUSY
);
  logic [7:0] ctl;
  int         busy_n;
  wire        ctl_wr = REG_WE && REG_ADDR == 8'h12;
  // Lagging busy flag hides a retrigger one cycle after the search ends
  wire        trig   = ctl_wr && ctl[6] && REG_WDATA[7:6] == 2'b10 && !CAL_BUSY;
  always_ff @(posedge CLK) ctl <= RST ? 8'h00 : (ctl_wr ? REG_WDATA : ctl);
  always_ff @(posedge CLK) busy_n <= CAL_BUSY ? busy_n + 1 : 0;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence wr_trig;
    trig;
  endsequence
  sequence busy_on;
    ##2 CAL_BUSY;
  endsequence
  cal_start_a: assert property (wr_trig |-> busy_on)
    else $error("calibration did not start");
  cal_cause_a: assert property ($rose(CAL_BUSY) |-> $past(trig, 2))
    else $error("calibration started without trigger");
  cal_len_a: assert property ($fell(CAL_BUSY) |-> busy_n == 6 * (SETTLE_CYCLES + 1))
    else $error("calibration length wrong");
  rd_pulse_a: assert property (REG_RVALID == $past(REG_RE))
    else $error("read valid not one cycle after strobe");
  loop_rd_a: assert property (REG_RE && REG_ADDR == 8'h14 && !REG_WE
    |=> REG_RDATA == {LOOP_BW, CP_CURRENT})
    else $error("loop fields differ from register");
  pwr_follow_a: assert property (ctl_wr |-> ##2 PLL_POWER_UP == $past(REG_WDATA[7], 2)
    && CLK_SEL_PLL == PLL_POWER_UP)
    else $error("power or clock select wrong");
  band_man_a: assert property ($past(ctl[6]) |-> VCO_BAND == $past(ctl[5:0]))
    else $error("manual band not applied");
  stat_busy_a: assert property (REG_RE && REG_ADDR == 8'h16 |=> REG_RDATA[6] == CAL_BUSY)
    else $error("status busy bit wrong");
endmodule : pvb_properties
bind pvb_top pvb_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_props (.CLK(CLK), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .PLL_POWER_UP(PLL_POWER_UP),
  .CLK_SEL_PLL(CLK_SEL_PLL), .VCO_BAND(VCO_BAND), .LOOP_BW(LOOP_BW),
  .CP_CURRENT(CP_CURRENT), .CAL_BUSY(CAL_BUSY));
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench of the PLL band select control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       CLK = 0, RST = 1, REG_WE = 0, REG_RE = 0, PLL_LOCK_IN = 0, VCO_FAST_IN = 0;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, DIV_SETTING;
  logic       REG_RVALID, PLL_POWER_UP, CLK_SEL_PLL, CAL_BUSY;
  logic [5:0] VCO_BAND;
  logic [2:0] LOOP_BW;
  logic [4:0] CP_CURRENT;
  logic [7:0] mloop = 8'he7, mdiv = 8'h00;
  int         n_fail = 0, n_compared = 0, seed = 71, tgt = 0, r, b;
  always #4 CLK = ~CLK;
  // Comparator model: VCO too fast while trial band is above target
  always @(negedge CLK) VCO_FAST_IN <= VCO_BAND > tgt;
  pvb_top #(.SETTLE_CYCLES(8)) i_dut (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .PLL_LOCK_IN(PLL_LOCK_IN), .VCO_FAST_IN(VCO_FAST_IN),
    .PLL_POWER_UP(PLL_POWER_UP), .CLK_SEL_PLL(CLK_SEL_PLL), .VCO_BAND(VCO_BAND),
    .LOOP_BW(LOOP_BW), .CP_CURRENT(CP_CURRENT), .DIV_SETTING(DIV_SETTING), .CAL_BUSY(CAL_BUSY));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    {REG_WE, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge CLK);
    REG_WE = 0;
    if (a == 8'h14) mloop = d;
    if (a == 8'h15) mdiv = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge CLK);
    {REG_RE, REG_ADDR} = {1'b1, a};
    @(negedge CLK);
    REG_RE = 0;
    chk(REG_RVALID, 1);
    chk(REG_RDATA, e);
  endtask : rd
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge CLK);
    RST = 0;
    rd(8'h14, 8'he7);
    rd(8'h12, 8'h00);
    wr(8'h33, 8'hff);
    rd(8'h33, 8'h00);
    repeat (3) begin
      r = $random(seed);
      wr(8'h14, r[7:0]);
      wr(8'h15, r[15:8]);
      @(negedge CLK);
      chk({LOOP_BW, CP_CURRENT}, mloop);
      chk(DIV_SETTING, mdiv);
      rd(8'h15, mdiv);
    end
    wr(8'h14, 8'he7);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 0 : (i == 1) ? 63 : $random(seed) & 63;
      wr(8'h12, b[7:0]);
      wr(8'h12, 8'h40 | b[7:0]);
      wr(8'h12, 8'hc0 | b[7:0]);
      @(negedge CLK);
      chk(VCO_BAND, b[5:0]);
      chk({PLL_POWER_UP, CLK_SEL_PLL}, 2'b11);
    end
    PLL_LOCK_IN = 1;
    for (int i = 0; i < 3; i++) begin
      tgt = (i == 0) ? 63 : (i == 1) ? 0 : $random(seed) & 63;
      wr(8'h12, 8'hc0);
      wr(8'h12, 8'h80);
      repeat (2) @(negedge CLK);
      chk(CAL_BUSY, 1);
      for (int k = 0; k < 200 && CAL_BUSY; k++) @(negedge CLK);
      chk(CAL_BUSY, 0);
      chk(VCO_BAND, tgt[5:0]);
      rd(8'h16, {2'b10, tgt[5:0]});
    end
    wr(8'h12, 8'h80);
    wr(8'h12, 8'h40);
    wr(8'h12, 8'h00);
    repeat (3) @(negedge CLK);
    chk(CAL_BUSY, 0);
    chk({PLL_POWER_UP, CLK_SEL_PLL}, 2'b00);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
